// file: shared/i2cam_pkg.sv
// How it works
// - General call address zero matches only while general_call_enable is set.
// - ten_bit_select 0 picks 7-bit addressing, 1 picks 10-bit addressing.
// - slave_id_high_bits give address bits 9:7, used only in 10-bit mode.
// - Span enabled, 7-bit mode only: match addresses above primary and up to span limit inclusive.
// - Span disabled: no range match, only primary and general call apply.
// - Filter blocks glitches up to setting cycles wide; zero bypasses it.
// - Reserved register bits read zero and ignore writes.
// - Filter register bit 7 writes change nothing.
// - span_limit_value sits in bits 7:1 of the upper-bound register.
// - Nonzero upper-bound write while span enabled arms it for matching.
// - Master first byte carries calling address in 7:1, read/write in 0.
package i2cam_pkg;

   // ----------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------
   localparam logic [5:0] IDX_ADDR_CTRL = 6'h05;
   localparam logic [5:0] IDX_FILTER    = 6'h06;
   localparam logic [5:0] IDX_SPAN      = 6'h07;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int GCE_BIT       = 7;
   localparam int TEN_BIT       = 6;
   localparam int SPAN_EN_BIT   = 3;
   localparam int HIGH_MSB      = 2;
   localparam int FLT_MSB       = 4;

   // ----------------------------------------
   // Reset values and encodings
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL_RST = 8'h00;
   localparam logic [4:0] FILTER_RST    = 5'h00;
   localparam logic [6:0] SPAN_RST      = 7'h00;
   localparam logic [7:0] GENERAL_CALL  = 8'h00;
   localparam logic [4:0] TEN_BIT_HDR   = 5'h1E;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Match source codes
   localparam logic [1:0] SRC_NONE    = 2'h0;
   localparam logic [1:0] SRC_PRIMARY = 2'h1;
   localparam logic [1:0] SRC_GENERAL = 2'h2;
   localparam logic [1:0] SRC_SPAN    = 2'h3;

   typedef enum logic [1:0]
   {
      I2CAM_IDLE  = 2'b00,
      I2CAM_FIRST = 2'b01,
      I2CAM_SECND = 2'b10,
      I2CAM_WAIT  = 2'b11
   } i2cam_state_t;

endpackage

// file: core/i2cam_glitch_filter.sv
`timescale 1ns/10ps
module i2cam_glitch_filter
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   // Setting
   input  wire logic [4:0] width_in,
   // Line
   input  wire logic       line_in,
   output logic            line_out
);

   logic       held_r;
   logic [4:0] run_r;

   // A change must persist for width+1 cycles before it is passed on
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         held_r <= 1'b1;
         run_r  <= 5'h00;
      end
      else if (line_in == held_r)
      begin
         run_r <= 5'h00;
      end
      else if (run_r >= width_in)
      begin
         held_r <= line_in;
         run_r  <= 5'h00;
      end
      else
      begin
         run_r <= run_r + 5'h01;
      end
   end

   // Zero setting bypasses the filter without added latency
   assign line_out = (width_in == 5'h00) ? line_in : held_r;

endmodule

// file: core/i2cam_top.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
module i2cam_top
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   // Wishbone slave
   input  wire logic       wb_cyc_in,
   input  wire logic       wb_stb_in,
   input  wire logic       wb_we_in,
   input  wire logic [7:0] wb_adr_in,
   input  wire logic [3:0] wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]     wb_dat_out,
   output logic            wb_ack_out,
   // Controller side
   input  wire logic [7:0] primary_slave_address_in,
   input  wire logic [6:0] call_address_in,
   input  wire logic       call_rw_in,
   output logic [7:0]      first_byte_out,
   // Bus lines (raw)
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   // Filtered lines and detection
   output logic            scl_filt_out,
   output logic            sda_filt_out,
   output logic            bus_busy_out,
   output logic            match_out,
   output logic [1:0]      match_source_out,
   output logic            match_rw_out,
   output logic [9:0]      match_address_out
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic        gce_r;
   logic        ten_bit_r;
   logic        span_en_r;
   logic [2:0]  high_bits_r;
   logic [4:0]  glitch_width_r;
   logic [6:0]  span_limit_r;
   logic        span_armed_r;
   logic        ack_r;
   logic [31:0] rd_data_r;
   logic [7:0]  rd_byte;
   logic [5:0]  idx;
   logic        wr_go;

   assign idx   = wb_adr_in[7:2];
   assign wr_go = wb_cyc_in & wb_stb_in & wb_we_in & ack_r & wb_sel_in[0];

   // Single wait state answer; ack drops the cycle after it was given
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         ack_r <= 1'b0;
      else
         ack_r <= wb_cyc_in & wb_stb_in & ~ack_r;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         gce_r       <= i2cam_pkg::ADDR_CTRL_RST[i2cam_pkg::GCE_BIT];
         ten_bit_r   <= i2cam_pkg::ADDR_CTRL_RST[i2cam_pkg::TEN_BIT];
         span_en_r   <= i2cam_pkg::ADDR_CTRL_RST[i2cam_pkg::SPAN_EN_BIT];
         high_bits_r <= i2cam_pkg::ADDR_CTRL_RST[i2cam_pkg::HIGH_MSB:0];
      end
      else if (wr_go && idx == i2cam_pkg::IDX_ADDR_CTRL)
      begin
         gce_r       <= wb_dat_in[i2cam_pkg::GCE_BIT];
         ten_bit_r   <= wb_dat_in[i2cam_pkg::TEN_BIT];
         span_en_r   <= wb_dat_in[i2cam_pkg::SPAN_EN_BIT];
         high_bits_r <= wb_dat_in[i2cam_pkg::HIGH_MSB:0];
      end
   end

   // Bits 7:5 are not stored, so their writes vanish
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         glitch_width_r <= i2cam_pkg::FILTER_RST;
      else if (wr_go && idx == i2cam_pkg::IDX_FILTER)
         glitch_width_r <= wb_dat_in[i2cam_pkg::FLT_MSB:0];
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         span_limit_r <= i2cam_pkg::SPAN_RST;
         span_armed_r <= 1'b0;
      end
      else if (wr_go && idx == i2cam_pkg::IDX_SPAN)
      begin
         span_limit_r <= wb_dat_in[7:1];
         span_armed_r <= span_en_r && (wb_dat_in[7:0] != 8'h00);
      end
   end

   // Read mux; reserved bits and unmapped words read zero
   always_comb
   begin
      rd_byte = 8'h00;
      case (idx)
         i2cam_pkg::IDX_ADDR_CTRL:
            rd_byte = {gce_r, ten_bit_r, 2'b00, span_en_r, high_bits_r};
         i2cam_pkg::IDX_FILTER:
            rd_byte = {3'b000, glitch_width_r};
         i2cam_pkg::IDX_SPAN:
            rd_byte = {span_limit_r, 1'b0};
         default:
            rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         rd_data_r <= 32'h00000000;
      else if (wb_cyc_in && wb_stb_in && !ack_r)
         rd_data_r <= {24'h000000, rd_byte};
   end

   assign wb_dat_out = rd_data_r;
   assign wb_ack_out = ack_r;

   // ----------------------------------------
   // Master calling byte
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         first_byte_out <= 8'h00;
      else
         first_byte_out <= {call_address_in, call_rw_in};
   end

   // ----------------------------------------
   // Input filters
   // ----------------------------------------
   logic [1:0] raw_lines;
   logic [1:0] filt_lines;

   assign raw_lines = {scl_in, sda_in};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_filt
         i2cam_glitch_filter u_filt
         (
            .clk_in   (clk_in),
            .reset_in (reset_in),
            .width_in (glitch_width_r),
            .line_in  (raw_lines[g]),
            .line_out (filt_lines[g])
         );
      end
   endgenerate

   assign scl_filt_out = filt_lines[1];
   assign sda_filt_out = filt_lines[0];

   // ----------------------------------------
   // Bus condition detection
   // ----------------------------------------
   logic scl_d_r;
   logic sda_d_r;
   logic start_det;
   logic stop_det;
   logic scl_rise;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= scl_filt_out;
         sda_d_r <= sda_filt_out;
      end
   end

   // Detection runs only on filtered lines so glitches cannot fake a start
   assign start_det = scl_filt_out & scl_d_r & sda_d_r & ~sda_filt_out;
   assign stop_det  = scl_filt_out & scl_d_r & ~sda_d_r & sda_filt_out;
   assign scl_rise  = scl_filt_out & ~scl_d_r;

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         bus_busy_out <= 1'b0;
      else if (start_det)
         bus_busy_out <= 1'b1;
      else if (stop_det)
         bus_busy_out <= 1'b0;
   end

   // ----------------------------------------
   // Address reception and matching
   // ----------------------------------------
   i2cam_pkg::i2cam_state_t state_r;
   i2cam_pkg::i2cam_state_t state_nxt;
   logic [7:0] shift_r;
   logic [3:0] bits_r;
   logic [7:0] byte_now;
   logic       byte_done;
   logic [7:0] first_r;
   logic [9:0] own_ten;
   logic [6:0] rx_addr7;
   logic       hit_primary;
   logic       hit_general;
   logic       hit_span;
   logic       hdr_ok;

   assign byte_now  = {shift_r[6:0], sda_filt_out};
   assign byte_done = scl_rise && (bits_r == i2cam_pkg::BITS_PER_BYTE - 4'h1);
   assign rx_addr7  = byte_now[7:1];
   assign own_ten   = {high_bits_r, primary_slave_address_in[7:1]};

   always_comb
   begin
      hit_general = gce_r && (byte_now == i2cam_pkg::GENERAL_CALL);
      hit_primary = !ten_bit_r && (rx_addr7 == primary_slave_address_in[7:1]);
      // Range only counts when enabled and armed by a nonzero limit write
      hit_span    = !ten_bit_r && span_en_r && span_armed_r
                    && (rx_addr7 > primary_slave_address_in[7:1])
                    && (rx_addr7 <= span_limit_r);
      hdr_ok      = ten_bit_r && (byte_now[7:3] == i2cam_pkg::TEN_BIT_HDR)
                    && (byte_now[2:1] == own_ten[9:8]);
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         shift_r <= 8'h00;
         bits_r  <= 4'h0;
      end
      else if (start_det)
      begin
         shift_r <= 8'h00;
         bits_r  <= 4'h0;
      end
      else if (scl_rise)
      begin
         shift_r <= byte_now;
         // Ninth clock is the acknowledge slot; restart count after it
         bits_r  <= (bits_r == i2cam_pkg::BITS_PER_BYTE) ? 4'h0 : bits_r + 4'h1;
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         i2cam_pkg::I2CAM_IDLE:
            if (start_det)
               state_nxt = i2cam_pkg::I2CAM_FIRST;
         i2cam_pkg::I2CAM_FIRST:
            if (byte_done)
               state_nxt = hdr_ok ? i2cam_pkg::I2CAM_SECND : i2cam_pkg::I2CAM_WAIT;
         i2cam_pkg::I2CAM_SECND:
            if (byte_done)
               state_nxt = i2cam_pkg::I2CAM_WAIT;
         i2cam_pkg::I2CAM_WAIT:
            state_nxt = state_r;
         default:
            state_nxt = i2cam_pkg::I2CAM_IDLE;
      endcase
      // Repeated start reopens address phase, stop closes it
      if (start_det)
         state_nxt = i2cam_pkg::I2CAM_FIRST;
      else if (stop_det)
         state_nxt = i2cam_pkg::I2CAM_IDLE;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         state_r <= i2cam_pkg::I2CAM_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         first_r <= 8'h00;
      else if (state_r == i2cam_pkg::I2CAM_FIRST && byte_done)
         first_r <= byte_now;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         match_out         <= 1'b0;
         match_source_out  <= i2cam_pkg::SRC_NONE;
         match_rw_out      <= 1'b0;
         match_address_out <= 10'h000;
      end
      else
      begin
         match_out <= 1'b0;
         if (state_r == i2cam_pkg::I2CAM_FIRST && byte_done)
         begin
            match_address_out <= {3'b000, rx_addr7};
            match_rw_out      <= byte_now[0];
            if (hit_general)
            begin
               match_out        <= 1'b1;
               match_source_out <= i2cam_pkg::SRC_GENERAL;
            end
            else if (hit_primary)
            begin
               match_out        <= 1'b1;
               match_source_out <= i2cam_pkg::SRC_PRIMARY;
            end
            else if (hit_span)
            begin
               match_out        <= 1'b1;
               match_source_out <= i2cam_pkg::SRC_SPAN;
            end
            else
               match_source_out <= i2cam_pkg::SRC_NONE;
         end
         else if (state_r == i2cam_pkg::I2CAM_SECND && byte_done)
         begin
            match_address_out <= {first_r[2:1], byte_now};
            match_rw_out      <= first_r[0];
            if (byte_now == own_ten[7:0])
            begin
               match_out        <= 1'b1;
               match_source_out <= i2cam_pkg::SRC_PRIMARY;
            end
            else
               match_source_out <= i2cam_pkg::SRC_NONE;
         end
      end
   end

endmodule

// file: tb/i2cam_asserts.sv
`timescale 1ns/10ps
module i2cam_asserts
(
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        reset_in,
   // Register bus
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [7:0]  wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   // Controller and lines
   input wire logic [7:0]  primary_slave_address_in,
   input wire logic [6:0]  call_address_in,
   input wire logic        call_rw_in,
   input wire logic [7:0]  first_byte_out,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        scl_filt_out,
   input wire logic        sda_filt_out,
   input wire logic        match_out,
   input wire logic [1:0]  match_source_out,
   input wire logic [9:0]  match_address_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic       rd;
   logic [5:0] idx;
   assign rd = wb_ack_out && !wb_we_in;
   assign idx = wb_adr_in[7:2];
   AST_ACK_ONE:
      assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
   AST_ACK_PULSE:
      assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
   AST_RSV_CTRL:
      assert property (rd && idx == 6'h05 |-> wb_dat_out[5:4] == 2'h0) else $error("ctrl rsv");
   AST_RSV_FLT:
      assert property (rd && idx == 6'h06 |-> wb_dat_out[7:5] == 3'h0) else $error("flt rsv");
   AST_RSV_SPAN:
      assert property (rd && idx == 6'h07 |-> wb_dat_out[0] == 1'b0) else $error("span rsv");
   AST_FIRST_BYTE:
      assert property (!$past(reset_in) |->
         first_byte_out == {$past(call_address_in), $past(call_rw_in)})
         else $error("first byte");
   // A filtered line may only move to a level its raw line recently held
   AST_SCL_FILT:
      assert property ($changed(scl_filt_out) |-> scl_filt_out == scl_in
         || scl_filt_out == $past(scl_in) || scl_filt_out == $past(scl_in, 2)) else $error("scl");
   AST_SDA_FILT:
      assert property ($changed(sda_filt_out) |-> sda_filt_out == sda_in
         || sda_filt_out == $past(sda_in) || sda_filt_out == $past(sda_in, 2)) else $error("sda");
   AST_GC_ADDR:
      assert property (match_source_out == 2'h2 |-> match_address_out == 10'h000) else $error("gc");
   AST_SPAN_LOW:
      assert property (match_source_out == 2'h3 |->
         match_address_out[6:0] > primary_slave_address_in[7:1]) else $error("span low");
   cover property (match_out && match_source_out == 2'h3);
   cover property (match_out && match_source_out == 2'h2);
   cover property (rd && idx == 6'h06);
endmodule

bind i2cam_top i2cam_asserts i_chk (.clk_in, .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
   .wb_adr_in, .wb_dat_out, .wb_ack_out, .primary_slave_address_in, .call_address_in,
   .call_rw_in, .first_byte_out, .scl_in, .sda_in, .scl_filt_out, .sda_filt_out, .match_out,
   .match_source_out, .match_address_out);

// file: tb/i2cam_master.sv
`timescale 1ns/10ps
module i2cam_master
#(
   parameter int HALF = 40
)
(
   // Clock
   input wire logic clk_in,
   // Lines, pulled up when released
   output logic     scl_out,
   output logic     sda_out
);
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic start_cond();
      hold(1);
      sda_out <= 1'b0;
      hold(HALF);
      scl_out <= 1'b0;
   endtask
   task automatic bit_out(input logic v);
      hold(HALF);
      sda_out <= v;
      hold(HALF);
      scl_out <= 1'b1;
      hold(HALF);
      scl_out <= 1'b0;
   endtask
   // Eight bits MSB first, then the ack slot with data released
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      bit_out(1'b1);
   endtask
   task automatic stop_cond();
      hold(HALF);
      sda_out <= 1'b0;
      hold(HALF);
      scl_out <= 1'b1;
      hold(HALF);
      sda_out <= 1'b1;
      hold(HALF);
   endtask
   task automatic glitch(input logic on_sda, input int n);
      hold(1);
      if (on_sda) sda_out <= 1'b0;
      else scl_out <= 1'b0;
      hold(n);
      sda_out <= 1'b1;
      scl_out <= 1'b1;
      hold(HALF);
   endtask
endmodule

// file: tb/tb_i2cam_top.sv
`timescale 1ns/10ps
module tb_i2cam_top;
   logic        clk_in = 1'b0;
   logic        reset_in, wb_cyc_in, wb_stb_in, wb_we_in, call_rw_in, wb_ack_out;
   logic        scl_in, sda_in, scl_filt_out, sda_filt_out, bus_busy_out, match_out, match_rw_out;
   logic [7:0]  wb_adr_in, primary_slave_address_in, first_byte_out, ctrl_m, span_m;
   logic [3:0]  wb_sel_in;
   logic [31:0] wb_dat_in, wb_dat_out, seed, q;
   logic [6:0]  call_address_in;
   logic [1:0]  match_source_out;
   logic [9:0]  match_address_out;
   logic        armed_m;
   int          error_cnt, check_count, lo_cnt, m_cnt, n0, w;
   logic [7:0]  msk [3] = '{8'hCF, 8'h1F, 8'hFE};
   logic [7:0]  cc [4] = '{8'h05, 8'h8F, 8'h08, 8'h88};
   logic [7:0]  sc [4] = '{8'h80, 8'h80, 8'h00, 8'h81};
   logic [7:0]  la [6] = '{8'h00, 8'h5B, 8'h5C, 8'h80, 8'h83, 8'h58};
   always #2 clk_in = ~clk_in;
   i2cam_top i_dut (.clk_in, .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .primary_slave_address_in,
      .call_address_in, .call_rw_in, .first_byte_out, .scl_in, .sda_in, .scl_filt_out,
      .sda_filt_out, .bus_busy_out, .match_out, .match_source_out, .match_rw_out,
      .match_address_out);
   i2cam_master i_mst (.clk_in(clk_in), .scl_out(scl_in), .sda_out(sda_in));
   always @(posedge clk_in)
   begin
      if (scl_filt_out === 1'b0 || sda_filt_out === 1'b0) lo_cnt++;
      if (match_out === 1'b1) m_cnt++;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string name, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         error_cnt++;
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Single classic cycle; the local model follows accepted control and limit writes only, not filter writes
   task automatic wb(input logic w_en, input logic [7:0] a, d, input logic [3:0] s);
      int n;
      @(posedge clk_in);
      {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, w_en};
      wb_adr_in <= a;
      wb_sel_in <= s;
      wb_dat_in <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (wb_ack_out !== 1'b1 && n < 20);
      q = wb_dat_out;
      {wb_cyc_in, wb_stb_in} <= 2'b00;
      if (n >= 20)
      begin
         error_cnt++;
         tally_and_finish();
      end
      if (w_en && s[0] && a == 8'h14) ctrl_m = d & 8'hCF;
      if (w_en && s[0] && a == 8'h1C) span_m = d & 8'hFE;
      if (w_en && s[0] && a == 8'h1C) armed_m = ctrl_m[3] && d != 8'h00;
   endtask
   // General call is the all-zero byte: address zero with a write bit
   function automatic logic [1:0] exp_src(input logic [7:0] b);
      logic [6:0] a;
      a = b[7:1];
      if (b == 8'h00 && ctrl_m[7]) return i2cam_pkg::SRC_GENERAL;
      if (a == primary_slave_address_in[7:1]) return i2cam_pkg::SRC_PRIMARY;
      if (ctrl_m[3] && armed_m && a > primary_slave_address_in[7:1] && a <= span_m[7:1])
         return i2cam_pkg::SRC_SPAN;
      return i2cam_pkg::SRC_NONE;
   endfunction
   task automatic addr7(input logic [7:0] b);
      logic [1:0] e;
      e = exp_src(b);
      n0 = m_cnt;
      i_mst.start_cond();
      i_mst.send_byte(b);
      check("busy", bus_busy_out, 1'b1);
      i_mst.stop_cond();
      check("source", match_source_out, e);
      check("pulses", m_cnt - n0, e != 2'h0);
      if (e != 2'h0) check("addr", {match_rw_out, match_address_out}, {b[0], 3'h0, b[7:1]});
   endtask
   initial
   begin
      reset_in = 1'b1;
      {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in} = '0;
      {call_address_in, call_rw_in, ctrl_m, span_m, armed_m} = '0;
      primary_slave_address_in = 8'h5A;
      seed = 9;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         wb(1'b0, 8'h14 + 8'(4 * i), 8'h00, 4'hF);
         check("reset", q, 32'h0);
         wb(1'b1, 8'h14 + 8'(4 * i), 8'hFF, 4'hF);
         wb(1'b0, 8'h14 + 8'(4 * i), 8'h00, 4'hF);
         check("mask", q, {24'h0, msk[i]});
      end
      wb(1'b1, 8'h14, 8'h00, 4'h0);
      wb(1'b1, 8'h20, 8'hFF, 4'hF);
      wb(1'b0, 8'h20, 8'h00, 4'hF);
      check("unmapped", q, 32'h0);
      wb(1'b0, 8'h14, 8'h00, 4'hF);
      check("lane", q, 32'hCF);
      repeat (4)
      begin
         @(posedge clk_in);
         {call_address_in, call_rw_in} <= 8'(rnd());
         repeat (2) @(posedge clk_in);
         check("first", first_byte_out, {call_address_in, call_rw_in});
      end
      for (int c = 0; c < 4; c++)
      begin
         // Limit first, then control: an armed range must still go quiet once disabled
         wb(1'b1, 8'h1C, sc[c], 4'hF);
         wb(1'b1, 8'h14, cc[c], 4'hF);
         for (int j = 0; j < 6; j++) addr7(la[j]);
         repeat (2) addr7(8'(rnd()));
      end
      wb(1'b1, 8'h14, 8'h45, 4'hF);
      for (int k = 0; k < 2; k++)
      begin
         i_mst.start_cond();
         i_mst.send_byte({5'h1E, 2'b10, 1'b0});
         i_mst.send_byte({~k[0], primary_slave_address_in[7:1]});
         i_mst.stop_cond();
         check("ten", match_source_out, k == 0 ? 2'h1 : 2'h0);
         if (k == 0) check("ten addr", match_address_out, {3'h5, 7'h2D});
      end
      wb(1'b1, 8'h14, 8'h00, 4'hF);
      w = 32'(rnd() % 31) + 1;
      for (int p = 0; p < 4; p++)
      begin
         wb(1'b1, 8'h18, p < 2 ? 8'(w) | 8'h80 : 8'h00, 4'hF);
         n0 = lo_cnt;
         if (p < 2) i_mst.glitch(p[0], w);
         check("blocked", lo_cnt - n0, 0);
         check("idle", bus_busy_out, 1'b0);
         i_mst.glitch(p[0], p < 2 ? w + 1 : 1);
         check("passed", lo_cnt > n0, 1);
      end
      tally_and_finish();
   end
endmodule
